// [rtl/bkpt_attr_consts.svh]
`ifndef BKPT_ATTR_CONSTS_SVH
`define BKPT_ATTR_CONSTS_SVH
// Debug control register number of the attribute reference register
`define ATTR_REG_NUM 5'h06
// Reset values
`define ATTR_REF_RESET 16'h0005
`define PORT_ATTR_RESET 8'h05
// Field positions inside the attribute reference register
`define F_DIR_MASK 15
`define F_SIZE_MASK 14:13
`define F_TYPE_MASK 12:11
`define F_MOD_MASK 10:8
`define F_DIR_REF 7
`define F_SIZE_REF 6:5
`define F_TYPE_REF 4:3
`define F_MOD_REF 2:0
`define F_ATTR 7:0
`define F_ALL_MASK 15:8
`define F_SUB_MASK 14:8
// Masks sit exactly eight bits above the reference bit they hide
`define MASK_BASE 8
// Size encodings
`define SIZE_LONG 2'h0
`define SIZE_BYTE 2'h1
`define SIZE_WORD 2'h2
`define SIZE_RSVD 2'h3
// Transfer type encodings
`define TYPE_NORMAL 2'h0
`define TYPE_EXT_DMA 2'h1
`define TYPE_EMUL 2'h2
`define TYPE_ACK 2'h3
// Transfer modifier encodings
`define MOD_CPU_SPACE 3'h0
`define MOD_USER_DATA 3'h1
`define MOD_USER_CODE 3'h2
`define MOD_IACK_MIN 3'h1
`define MOD_IACK_MAX 3'h4
`define IACK_NONE 3'h0
`endif

// [rtl/bkpt_attr_pkg.sv]
package bkpt_attr_pkg;
  // Meaning of the reference modifier in the context of its type
  typedef enum logic [2:0] {
    CLS_RESERVED = 3'h0,
    CLS_USER_DATA = 3'h1,
    CLS_USER_CODE = 3'h2,
    CLS_CPU_SPACE = 3'h3,
    CLS_INT_ACK = 3'h4
  } ref_class_e;

  // Whole state of the matcher
  typedef struct packed {
    logic [15:0] attr_ref;
    logic [7:0] port_attr;
    logic match;
    ref_class_e ref_class;
    logic [2:0] iack_level;
    logic ref_reserved;
    logic ext_access;
  } matcher_state_s;
endpackage

// [rtl/breakpoint_attribute_matcher.sv]
`timescale 1ns/100ps
`include "bkpt_attr_consts.svh"
module breakpoint_attribute_matcher #(
  parameter int ATTR_BITS = 8
) (
  input wire logic CLK, // Core clock
  input wire logic RST, // Synchronous reset, high
  input wire logic CORE_WR_STB, // Core debug register write strobe
  input wire logic [4:0] CORE_WR_NUM, // Core debug register number
  input wire logic [15:0] CORE_WR_DATA, // Core write data
  input wire logic PORT_WR_STB, // Debug port register write strobe
  input wire logic [4:0] PORT_WR_NUM, // Debug port register number
  input wire logic [15:0] PORT_WR_DATA, // Debug port write data
  input wire logic TRIG_ENABLE, // Attribute qualification enabled
  input wire logic LB_VALID, // Local bus transfer valid
  input wire logic LB_READ, // Local bus direction, high read
  input wire logic [1:0] LB_SIZE, // Local bus size
  input wire logic [1:0] LB_XFER_TYPE, // Local bus transfer type
  input wire logic [2:0] LB_XFER_MOD, // Local bus transfer modifier
  output logic ATTR_MATCH, // Attribute hit, one cycle late
  output logic [15:0] ATTR_REF, // Stored reference and masks
  output logic [7:0] DBG_PORT_ATTR, // Debug port attribute register
  output logic [2:0] REF_CLASS, // Decoded reference modifier class
  output logic [2:0] REF_IACK_LEVEL, // Acknowledge level, zero if none
  output logic REF_RESERVED, // Reference uses a reserved code
  output logic DBG_EXT_ACCESS // Port memory type is external/DMA
);

  bkpt_attr_pkg::matcher_state_s st;
  bkpt_attr_pkg::matcher_state_s next_st;

  logic core_hit;
  logic port_hit;
  logic [ATTR_BITS-1:0] bus_attr;
  logic [ATTR_BITS-1:0] bit_ok;

  // Write decode; the debug port wins a same-cycle collision
  assign core_hit = CORE_WR_STB && (CORE_WR_NUM == `ATTR_REG_NUM);
  assign port_hit = PORT_WR_STB && (PORT_WR_NUM == `ATTR_REG_NUM);

  // Bus attributes packed in the same order as the reference byte
  assign bus_attr = {LB_READ, LB_SIZE, LB_XFER_TYPE, LB_XFER_MOD};

  // Per-bit compare; each mask bit sits eight above its reference bit
  genvar gi;
  generate
    for (gi = 0; gi < ATTR_BITS; gi++) begin : g_cmp
      assign bit_ok[gi] = st.attr_ref[`MASK_BASE+gi] ||
                          (st.attr_ref[gi] == bus_attr[gi]);
    end
  endgenerate

  // Decode the modifier in the light of the type it goes with
  function automatic bkpt_attr_pkg::ref_class_e decode_class(
    input logic [1:0] xtype,
    input logic [2:0] xmod
  );
    bkpt_attr_pkg::ref_class_e cls;
    cls = bkpt_attr_pkg::CLS_RESERVED;
    case (xtype)
      `TYPE_NORMAL: begin
        if (xmod == `MOD_USER_DATA) begin
          cls = bkpt_attr_pkg::CLS_USER_DATA;
        end else if (xmod == `MOD_USER_CODE) begin
          cls = bkpt_attr_pkg::CLS_USER_CODE;
        end
      end
      `TYPE_ACK: begin
        if (xmod == `MOD_CPU_SPACE) begin
          cls = bkpt_attr_pkg::CLS_CPU_SPACE;
        end else if (xmod <= `MOD_IACK_MAX) begin
          cls = bkpt_attr_pkg::CLS_INT_ACK;
        end
      end
      // Emulator and the reserved type leave every modifier reserved
      default: begin
        cls = bkpt_attr_pkg::CLS_RESERVED;
      end
    endcase
    return cls;
  endfunction

  // Next state; decode uses the incoming reference so flags line up
  always_comb begin
    next_st = st;
    if (port_hit) begin
      next_st.attr_ref = PORT_WR_DATA;
      next_st.port_attr = PORT_WR_DATA[`F_ATTR];
    end else if (core_hit) begin
      next_st.attr_ref = CORE_WR_DATA;
      next_st.port_attr = CORE_WR_DATA[`F_ATTR];
    end
    // Match is judged on the reference that stood during the transfer
    next_st.match = LB_VALID && TRIG_ENABLE && (&bit_ok);
    next_st.ref_class = decode_class(next_st.attr_ref[`F_TYPE_REF],
                                     next_st.attr_ref[`F_MOD_REF]);
    if (next_st.ref_class == bkpt_attr_pkg::CLS_INT_ACK) begin
      next_st.iack_level = next_st.attr_ref[`F_MOD_REF];
    end else begin
      next_st.iack_level = `IACK_NONE;
    end
    // Reserved codes still compare bit by bit; this flag only warns software
    next_st.ref_reserved = (next_st.attr_ref[`F_SIZE_REF] == `SIZE_RSVD) ||
                           (next_st.attr_ref[`F_TYPE_REF] == `TYPE_EXT_DMA);
    // On the debug port the otherwise reserved type means external/DMA
    next_st.ext_access = (next_st.port_attr[`F_TYPE_REF] == `TYPE_EXT_DMA);
  end

  // State register
  always_ff @(posedge CLK) begin
    if (RST) begin
      st.attr_ref <= `ATTR_REF_RESET;
      st.port_attr <= `PORT_ATTR_RESET;
      st.match <= 1'b0;
      st.ref_class <= bkpt_attr_pkg::CLS_RESERVED;
      st.iack_level <= `IACK_NONE;
      st.ref_reserved <= 1'b0;
      st.ext_access <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state flops
  assign ATTR_MATCH = st.match;
  assign ATTR_REF = st.attr_ref;
  assign DBG_PORT_ATTR = st.port_attr;
  assign REF_CLASS = st.ref_class;
  assign REF_IACK_LEVEL = st.iack_level;
  assign REF_RESERVED = st.ref_reserved;
  assign DBG_EXT_ACCESS = st.ext_access;

  // Checks on the matcher and its register
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  // Shorthands used only by the checks
  logic qual;
  assign qual = LB_VALID && TRIG_ENABLE;

  // No hit without a qualified transfer in the cycle before
  match_needs_xfer_a: assert property (
    ATTR_MATCH |-> $past(LB_VALID) && $past(TRIG_ENABLE))
    else $error("match without qualified transfer");

  // An unmasked direction mismatch blocks the hit
  dir_compare_a: assert property (
    qual && !ATTR_REF[`F_DIR_MASK] && (LB_READ != ATTR_REF[`F_DIR_REF])
    |=> !ATTR_MATCH)
    else $error("direction mismatch still matched");

  // With all masks set any qualified transfer hits
  all_masked_a: assert property (
    qual && (ATTR_REF[`F_ALL_MASK] == 8'hff) |=> ATTR_MATCH)
    else $error("fully masked compare missed");

  // Direction masked, all other masks set: a write hits
  dir_masked_a: assert property (
    qual && ATTR_REF[`F_DIR_MASK] && (ATTR_REF[`F_SUB_MASK] == 7'h7f) && !LB_READ
    |=> ATTR_MATCH)
    else $error("masked direction blocked match");

  // Unmasked size bit mismatch blocks the hit
  size_bit_a: assert property (
    qual && (|((LB_SIZE ^ ATTR_REF[`F_SIZE_REF]) & ~ATTR_REF[`F_SIZE_MASK]))
    |=> !ATTR_MATCH)
    else $error("size mismatch still matched");

  // Unmasked type bit mismatch blocks the hit
  type_bit_a: assert property (
    qual && (|((LB_XFER_TYPE ^ ATTR_REF[`F_TYPE_REF]) & ~ATTR_REF[`F_TYPE_MASK]))
    |=> !ATTR_MATCH)
    else $error("type mismatch still matched");

  // Unmasked modifier bit mismatch blocks the hit
  mod_bit_a: assert property (
    qual && (|((LB_XFER_MOD ^ ATTR_REF[`F_MOD_REF]) & ~ATTR_REF[`F_MOD_MASK]))
    |=> !ATTR_MATCH)
    else $error("modifier mismatch still matched");

  // Exact unmasked equality hits
  exact_hit_a: assert property (
    qual && (bus_attr == ATTR_REF[`F_ATTR]) |=> ATTR_MATCH)
    else $error("exact attributes missed");

  // Core write loads both registers
  core_write_a: assert property (
    core_hit && !port_hit |=> (ATTR_REF == $past(CORE_WR_DATA)) &&
    (DBG_PORT_ATTR == $past(CORE_WR_DATA[`F_ATTR])))
    else $error("core write not loaded");

  // Port write loads both registers
  port_write_a: assert property (
    port_hit |=> (ATTR_REF == $past(PORT_WR_DATA)) &&
    (DBG_PORT_ATTR == $past(PORT_WR_DATA[`F_ATTR])))
    else $error("port write not loaded");

  // Writes to other numbers leave the register alone
  other_num_a: assert property (
    !core_hit && !port_hit |=> $stable(ATTR_REF) && $stable(DBG_PORT_ATTR))
    else $error("register changed without write");

  // Acknowledge type with an in-range modifier gives its level
  iack_level_a: assert property (
    (ATTR_REF[`F_TYPE_REF] == `TYPE_ACK) && (ATTR_REF[`F_MOD_REF] >= `MOD_IACK_MIN) &&
    (ATTR_REF[`F_MOD_REF] <= `MOD_IACK_MAX)
    |-> (REF_CLASS == bkpt_attr_pkg::CLS_INT_ACK) &&
    (REF_IACK_LEVEL == ATTR_REF[`F_MOD_REF]))
    else $error("interrupt acknowledge decode wrong");

  // Emulator type keeps every modifier reserved
  emul_class_a: assert property (
    ATTR_REF[`F_TYPE_REF] == `TYPE_EMUL |-> REF_CLASS == bkpt_attr_pkg::CLS_RESERVED)
    else $error("emulator modifier not reserved");

  // Normal type user code decode
  code_class_a: assert property (
    (ATTR_REF[`F_TYPE_REF] == `TYPE_NORMAL) && (ATTR_REF[`F_MOD_REF] == `MOD_USER_CODE)
    |-> REF_CLASS == bkpt_attr_pkg::CLS_USER_CODE)
    else $error("user code decode wrong");

  // Debug port type 01 flags external access
  ext_access_a: assert property (
    DBG_EXT_ACCESS == (DBG_PORT_ATTR[`F_TYPE_REF] == `TYPE_EXT_DMA))
    else $error("external access flag wrong");

  // Checks on reset, the full masked compare, decode and the port copy

  // Reset brings back the defaults; the default reference decodes as reserved
  reset_value_a: assert property (disable iff (1'b0)
    RST |=> (ATTR_REF == `ATTR_REF_RESET) && (DBG_PORT_ATTR == `PORT_ATTR_RESET) &&
    !ATTR_MATCH && (REF_CLASS == bkpt_attr_pkg::CLS_RESERVED))
    else $error("reset values wrong");

  // The port attribute register always mirrors the reference byte
  port_copy_a: assert property (
    DBG_PORT_ATTR == ATTR_REF[`F_ATTR])
    else $error("port attribute copy drifted");

  // Colliding writes keep the debug port's word
  port_wins_a: assert property (
    core_hit && port_hit |=> (ATTR_REF == $past(PORT_WR_DATA)))
    else $error("collision kept the core word");

  // No qualified transfer, no hit one cycle later
  idle_no_hit_a: assert property (
    !qual |=> !ATTR_MATCH)
    else $error("hit after an idle cycle");

  // Every unmasked bit equal is enough for a hit, whatever the masked bits hold
  masked_equal_a: assert property (
    qual && (((bus_attr ^ ATTR_REF[`F_ATTR]) & ~ATTR_REF[`F_ALL_MASK]) == '0)
    |=> ATTR_MATCH)
    else $error("masked compare missed");

  // Normal type user data decode
  data_class_a: assert property (
    (ATTR_REF[`F_TYPE_REF] == `TYPE_NORMAL) && (ATTR_REF[`F_MOD_REF] == `MOD_USER_DATA)
    |-> REF_CLASS == bkpt_attr_pkg::CLS_USER_DATA)
    else $error("user data decode wrong");

  // Acknowledge type with modifier zero is a CPU space access, no level
  cpu_space_a: assert property (
    (ATTR_REF[`F_TYPE_REF] == `TYPE_ACK) && (ATTR_REF[`F_MOD_REF] == `MOD_CPU_SPACE)
    |-> (REF_CLASS == bkpt_attr_pkg::CLS_CPU_SPACE) && (REF_IACK_LEVEL == `IACK_NONE))
    else $error("cpu space decode wrong");

  // Normal type modifiers other than data and code stay reserved
  normal_rsvd_a: assert property (
    (ATTR_REF[`F_TYPE_REF] == `TYPE_NORMAL) && (ATTR_REF[`F_MOD_REF] != `MOD_USER_DATA) &&
    (ATTR_REF[`F_MOD_REF] != `MOD_USER_CODE)
    |-> REF_CLASS == bkpt_attr_pkg::CLS_RESERVED)
    else $error("normal modifier not reserved");

  // A level is only reported for an interrupt acknowledge
  iack_none_a: assert property (
    REF_CLASS != bkpt_attr_pkg::CLS_INT_ACK |-> REF_IACK_LEVEL == `IACK_NONE)
    else $error("level without acknowledge");

  // Reserved size and type codes raise the warning flag, nothing else does
  rsvd_flag_a: assert property (
    REF_RESERVED == ((ATTR_REF[`F_SIZE_REF] == `SIZE_RSVD) ||
    (ATTR_REF[`F_TYPE_REF] == `TYPE_EXT_DMA)))
    else $error("reserved flag wrong");

  // Decode outputs hold while nothing is written
  class_hold_a: assert property (
    !core_hit && !port_hit |=> $stable(REF_CLASS) && $stable(REF_IACK_LEVEL))
    else $error("decode changed without write");

  // Main scenarios
  hit_cov: cover property (qual ##1 ATTR_MATCH);
  masked_hit_cov: cover property (qual && ATTR_REF[`F_DIR_MASK] ##1 ATTR_MATCH);
  write_then_hit_cov: cover property (core_hit ##1 qual ##1 ATTR_MATCH);
  collide_cov: cover property (core_hit && port_hit);
  iack_cov: cover property (REF_CLASS == bkpt_attr_pkg::CLS_INT_ACK);

endmodule

// [test/lbus_host_model.sv]
`timescale 1ns/100ps
// Core, debug host and local bus stand-in; everything moves on the rising edge
module lbus_host_model (
  input wire logic CLK, // Core clock
  output logic CORE_WR_STB, // Core write strobe
  output logic [4:0] CORE_WR_NUM, // Core register number
  output logic [15:0] CORE_WR_DATA, // Core write data
  output logic PORT_WR_STB, // Port write strobe
  output logic [4:0] PORT_WR_NUM, // Port register number
  output logic [15:0] PORT_WR_DATA, // Port write data
  output logic TRIG_ENABLE, // Qualification enable
  output logic LB_VALID, // Bus transfer valid
  output logic LB_READ, // Bus direction
  output logic [1:0] LB_SIZE, // Bus size
  output logic [1:0] LB_XFER_TYPE, // Bus transfer type
  output logic [2:0] LB_XFER_MOD // Bus transfer modifier
);
  // Quiet bus at time zero
  initial begin
    {CORE_WR_STB, PORT_WR_STB, LB_VALID, TRIG_ENABLE} = 4'h0;
    {CORE_WR_NUM, PORT_WR_NUM} = 10'h000;
    {CORE_WR_DATA, PORT_WR_DATA} = 32'h00000000;
    {LB_READ, LB_SIZE, LB_XFER_TYPE, LB_XFER_MOD} = 8'h00;
  end

  // One-cycle write strobe from the core, the port or both at once
  task automatic wr(input logic c, input logic p, input logic [4:0] num,
                    input logic [15:0] cd, input logic [15:0] pd);
    @(posedge CLK);
    CORE_WR_STB <= c;
    PORT_WR_STB <= p;
    CORE_WR_NUM <= num;
    PORT_WR_NUM <= num;
    CORE_WR_DATA <= cd;
    PORT_WR_DATA <= pd;
    @(posedge CLK);
    CORE_WR_STB <= 1'b0;
    PORT_WR_STB <= 1'b0;
    // Inverted data after release so a stale value cannot pass
    CORE_WR_DATA <= ~cd;
    PORT_WR_DATA <= ~pd;
  endtask

  // One bus cycle carrying {read, size, type, modifier}
  task automatic bus(input logic v, input logic en, input logic [7:0] a);
    @(posedge CLK);
    LB_VALID <= v;
    TRIG_ENABLE <= en;
    {LB_READ, LB_SIZE, LB_XFER_TYPE, LB_XFER_MOD} <= a;
    @(posedge CLK);
    LB_VALID <= 1'b0;
    {LB_READ, LB_SIZE, LB_XFER_TYPE, LB_XFER_MOD} <= ~a;
  endtask
endmodule

// [test/breakpoint_attribute_matcher_test.sv]
`timescale 1ns/100ps
module breakpoint_attribute_matcher_test;
  logic CLK = 1'b0;
  logic RST;
  logic c_stb, p_stb, en, valid, rd, match, rsv, ext;
  logic [4:0] c_num, p_num;
  logic [15:0] c_data, p_data, ref_val;
  logic [1:0] sz, xt;
  logic [2:0] xm, cls, lvl;
  logic [7:0] port_attr, a;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  // Reference byte, then class, level, reserved and external flags
  logic [15:0] dec_tab [0:11] = '{16'h0120, 16'h0240, 16'h0000, 16'h1100, 16'h1860,
    16'h1984, 16'h1a88, 16'h1b8c, 16'h1c90, 16'h1d00, 16'h6122, 16'h0903};

  always #4 CLK = ~CLK;

  lbus_host_model host_u (.CLK(CLK), .CORE_WR_STB(c_stb), .CORE_WR_NUM(c_num),
    .CORE_WR_DATA(c_data), .PORT_WR_STB(p_stb), .PORT_WR_NUM(p_num), .PORT_WR_DATA(p_data),
    .TRIG_ENABLE(en), .LB_VALID(valid), .LB_READ(rd), .LB_SIZE(sz), .LB_XFER_TYPE(xt),
    .LB_XFER_MOD(xm));

  breakpoint_attribute_matcher dut_u (.CLK(CLK), .RST(RST), .CORE_WR_STB(c_stb),
    .CORE_WR_NUM(c_num), .CORE_WR_DATA(c_data), .PORT_WR_STB(p_stb), .PORT_WR_NUM(p_num),
    .PORT_WR_DATA(p_data), .TRIG_ENABLE(en), .LB_VALID(valid), .LB_READ(rd), .LB_SIZE(sz),
    .LB_XFER_TYPE(xt), .LB_XFER_MOD(xm), .ATTR_MATCH(match), .ATTR_REF(ref_val),
    .DBG_PORT_ATTR(port_attr), .REF_CLASS(cls), .REF_IACK_LEVEL(lvl), .REF_RESERVED(rsv),
    .DBG_EXT_ACCESS(ext));

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Write, then look at the stored word and its low-byte copy
  task automatic put(input logic c, input logic p, input logic [4:0] num,
                     input logic [15:0] cd, input logic [15:0] pd, input logic [15:0] exp);
    host_u.wr(c, p, num, cd, pd);
    #1;
    chk("attr_ref", ref_val, exp);
    chk("port_attr", 16'(port_attr), 16'(exp[7:0]));
  endtask

  // Bus cycle, then the match one edge later
  task automatic cmp(input logic v, input logic e, input logic [7:0] x, input logic exp);
    host_u.bus(v, e, x);
    #1;
    chk("attr_match", 16'(match), 16'(exp));
  endtask

  // Bound on the whole run; a hang counts as a mismatch
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      end_sim();
    end
  end

  initial begin
    RST = 1'b1;
    repeat (2) @(posedge CLK);
    #1;
    chk("ref_reset", ref_val, 16'h0005);
    chk("port_reset", 16'(port_attr), 16'h0005);
    chk("match_reset", 16'(match), 16'h0000);
    @(posedge CLK);
    RST <= 1'b0;
    put(1'b1, 1'b0, 5'h07, 16'h00ff, 16'h0000, 16'h0005);
    put(1'b0, 1'b1, 5'h05, 16'h0000, 16'h00ff, 16'h0005);
    put(1'b1, 1'b1, 5'h06, 16'h00aa, 16'h0055, 16'h0055);
    // Modifier meaning under each transfer type, through both write paths
    for (int i = 0; i < 12; i++) begin
      put(i[0], ~i[0], 5'h06, {8'h00, dec_tab[i][15:8]}, {8'h00, dec_tab[i][15:8]},
          {8'h00, dec_tab[i][15:8]});
      chk("ref_class", 16'(cls), 16'(dec_tab[i][7:5]));
      chk("iack_level", 16'(lvl), 16'(dec_tab[i][4:2]));
      chk("ref_reserved", 16'(rsv), 16'(dec_tab[i][1]));
      chk("ext_access", 16'(ext), 16'(dec_tab[i][0]));
    end
    // Each attribute bit must match unless its own mask bit hides it
    a = 8'hb9;
    for (int i = 0; i < 8; i++) begin
      put(1'b1, 1'b0, 5'h06, {8'h00, a}, 16'h0000, {8'h00, a});
      cmp(1'b1, 1'b1, a, 1'b1);
      cmp(1'b1, 1'b1, a ^ (8'h01 << i), 1'b0);
      put(1'b0, 1'b1, 5'h06, 16'h0000, {8'h01 << i, a}, {8'h01 << i, a});
      cmp(1'b1, 1'b1, a ^ (8'h01 << i), 1'b1);
    end
    cmp(1'b0, 1'b1, a, 1'b0);
    cmp(1'b1, 1'b0, a, 1'b0);
    put(1'b1, 1'b0, 5'h06, 16'hff00, 16'h0000, 16'hff00);
    cmp(1'b1, 1'b1, ~a, 1'b1);
    // The hit stands for one cycle only once the transfer has gone
    @(posedge CLK);
    #1;
    chk("match_drop", 16'(match), 16'h0000);
    // Reset in mid-run puts the defaults back over a written reference
    @(posedge CLK);
    RST <= 1'b1;
    repeat (2) @(posedge CLK);
    #1;
    chk("ref_rerst", ref_val, 16'h0005);
    chk("port_rerst", 16'(port_attr), 16'h0005);
    chk("class_rerst", 16'(cls), 16'h0000);
    chk("match_rerst", 16'(match), 16'h0000);
    @(posedge CLK);
    RST <= 1'b0;
    // First write straight after the release is taken
    put(1'b1, 1'b0, 5'h06, 16'h0019, 16'h0000, 16'h0019);
    chk("iack_rerst", 16'(lvl), 16'h0001);
    end_sim();
  end
endmodule
